// File: design/pleic_phy_led_int.sv
/*
 * indicator selection, receive-error tally and interrupt pin control
 * for a physical-layer device's extended management registers.
 * assumes a one-cycle read/write strobe from the serial management
 * logic, all inputs synchronous to clock, and status levels from the phy.
 */
// What this block does
// - second indicator source from 3-bit code
// - first indicator same codes, 111 link
// - 16-bit receive error tally, management writable
// - output enable bit gates interrupt pin
// - read-clear bit clears flags on read
// - polarity bit picks asserted pin level
// - auto-clear drops flag when condition ends
// - re-setup keeps written flag while condition
// - enable for deep power down wakeup
// - enable for deep power down entry
// - enable for auto-negotiation complete
// - flags register records each event occurrence
`timescale 1ns/1ps
module pleic_phy_led_int
    import pleic_pkg::*;
#(
    parameter int TALLY_W = 16
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  srst,
    // management register port
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    input  wire logic [4:0]            regIndex,
    input  wire logic [15:0]           regWdata,
    output logic      [15:0]           regRdata,
    // phy status levels and receive-error pulse
    input  wire logic                  linkUp,
    input  wire logic                  activity,
    input  wire logic                  txActive,
    input  wire logic                  rxActive,
    input  wire logic                  speed100,
    input  wire logic                  fullDuplex,
    input  wire logic                  rxErrorPulse,
    // event conditions: wake, power-down entry, autoneg complete
    input  wire logic [NUM_EVENTS-1:0] eventCond,
    // outputs
    output logic                       firstIndicator,
    output logic                       secondIndicator,
    output logic                       intPin,
    output logic                       intPinOe
);
    initial begin
        if (TALLY_W != 16) $error("tally must be 16 bits wide");
    end

    logic [15:0]           indicatorCfg;
    logic [15:0]           rxErrorTally;
    logic [15:0]           intCtrl;
    logic [NUM_EVENTS-1:0] intFlags;
    logic [NUM_EVENTS-1:0] condPrev;

    // register decode
    wire wrInd   = regWrite && regIndex == REG_INDICATOR;
    wire wrTally = regWrite && regIndex == REG_RX_TALLY;
    wire wrCtrl  = regWrite && regIndex == REG_INT_CTRL;
    wire wrFlags = regWrite && regIndex == REG_INT_FLAGS;
    wire rdFlags = regRead  && regIndex == REG_INT_FLAGS;

    wire [2:0] firstSel  = indicatorCfg[FIRST_SEL_LSB +: 3];
    wire [2:0] secondSel = indicatorCfg[SECOND_SEL_LSB +: 3];
    wire [NUM_EVENTS-1:0] eventEn   = intCtrl[EVENT_LSB +: NUM_EVENTS];
    wire [NUM_EVENTS-1:0] condRise  = eventCond & ~condPrev;

    // shared source mux; code 111 differs per indicator
    function automatic logic pick(input logic [2:0] sel, input logic lastVal);
        unique case (sel)
            SEL_LINK:     pick = linkUp;
            SEL_ACTIVITY: pick = activity;
            SEL_TX_DATA:  pick = txActive;
            SEL_RX_DATA:  pick = rxActive;
            SEL_UNSUPP:   pick = 1'b0;
            SEL_SPEED:    pick = speed100;
            SEL_DUPLEX:   pick = fullDuplex;
            SEL_LAST:     pick = lastVal;
        endcase
    endfunction
    wire nextFirst  = pick(firstSel, linkUp);
    wire nextSecond = pick(secondSel, 1'b0);

    // pin: enabled flag pending and output enabled, at chosen polarity
    wire intActive = intCtrl[OUT_EN_BIT] && |(intFlags & eventEn);
    wire next_intPin = intActive ? intCtrl[POLARITY_BIT] : ~intCtrl[POLARITY_BIT];

    // per-flag next value; set beats every clear
    logic [NUM_EVENTS-1:0] next_intFlags;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_flag
            wire clrRead  = rdFlags && intCtrl[READ_CLR_BIT];
            wire clrAuto  = intCtrl[AUTO_CLR_BIT] && !eventCond[gi];
            wire clrWrite = wrFlags && regWdata[EVENT_LSB + gi]
                            && !(intCtrl[RESETUP_BIT] && eventCond[gi]);
            assign next_intFlags[gi] = condRise[gi] ||
                                       (intFlags[gi] && !(clrRead || clrAuto || clrWrite));
        end
    endgenerate

    // tally increments on receive error; management write wins
    wire [15:0] next_tally = wrTally ? regWdata
                           : rxErrorPulse ? 16'(rxErrorTally + 16'h0001) : rxErrorTally;

    // read data mux; unknown indices read zero
    wire [15:0] next_rdata =
        regIndex == REG_INDICATOR ? indicatorCfg :
        regIndex == REG_RX_TALLY  ? rxErrorTally :
        regIndex == REG_INT_CTRL  ? intCtrl :
        regIndex == REG_INT_FLAGS ? {5'h00, intFlags, 8'h00} : 16'h0000;

    // register state
    always_ff @(posedge clock) begin
        if (srst) begin
            indicatorCfg <= INDICATOR_RST;
            rxErrorTally <= RX_TALLY_RST;
            intCtrl      <= INT_CTRL_RST;
            intFlags     <= '0;
            condPrev     <= '0;
        end else begin
            if (wrInd) indicatorCfg <= regWdata;
            if (wrCtrl) intCtrl <= {regWdata[15:8], 8'h00};
            rxErrorTally <= next_tally;
            intFlags     <= next_intFlags;
            condPrev     <= eventCond;
        end
    end
    // registered outputs; pin idles deasserted (high for active low)
    always_ff @(posedge clock) begin
        if (srst) begin
            firstIndicator  <= 1'b0;
            secondIndicator <= 1'b0;
            intPin          <= 1'b1;
            intPinOe        <= 1'b0;
            regRdata        <= 16'h0000;
        end else begin
            firstIndicator  <= nextFirst;
            secondIndicator <= nextSecond;
            intPin          <= next_intPin;
            intPinOe        <= intCtrl[OUT_EN_BIT];
            regRdata        <= next_rdata;
        end
    end

    // checks
    property p_pin_level;
        @(posedge clock) disable iff (srst)
        1'b1 |=> intPin == ($past(intActive) ? $past(intCtrl[POLARITY_BIT])
                                      : !$past(intCtrl[POLARITY_BIT]));
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

    property p_pin_off;
        @(posedge clock) disable iff (srst)
        !intCtrl[OUT_EN_BIT] |=> !intPinOe;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin enabled while off");

    property p_flag_set;
        @(posedge clock) disable iff (srst)
        condRise[0] |=> intFlags[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost");

    property p_read_clear;
        @(posedge clock) disable iff (srst)
        rdFlags && intCtrl[READ_CLR_BIT] && !condRise[0] |=> !intFlags[0];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_read_keep;
        @(posedge clock) disable iff (srst)
        rdFlags && !intCtrl[READ_CLR_BIT] && !intCtrl[AUTO_CLR_BIT] && !wrFlags
            && intFlags[0] |=> intFlags[0];
    endproperty
    a_read_keep: assert property (p_read_keep) else $error("read cleared flag");

    property p_auto_clear;
        @(posedge clock) disable iff (srst)
        intCtrl[AUTO_CLR_BIT] && !eventCond[0] |=> !intFlags[0];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto clear failed");

    property p_resetup;
        @(posedge clock) disable iff (srst)
        intCtrl[RESETUP_BIT] && eventCond[0] && intFlags[0]
            && !(rdFlags && intCtrl[READ_CLR_BIT]) |=> intFlags[0];
    endproperty
    a_resetup: assert property (p_resetup) else $error("flag dropped while held");

    property p_tally;
        @(posedge clock) disable iff (srst)
        rxErrorPulse && !wrTally |=> rxErrorTally == 16'($past(rxErrorTally) + 16'h0001);
    endproperty
    a_tally: assert property (p_tally) else $error("tally miscount");

    property p_masked;
        @(posedge clock) disable iff (srst)
        eventEn == '0 |=> intPin == !$past(intCtrl[POLARITY_BIT]);
    endproperty
    a_masked: assert property (p_masked) else $error("masked event drove pin");

    property p_first_link;
        @(posedge clock) disable iff (srst)
        firstSel == SEL_LAST |=> firstIndicator == $past(linkUp);
    endproperty
    a_first_link: assert property (p_first_link) else $error("first 111 wrong");

    property p_second_off;
        @(posedge clock) disable iff (srst)
        secondSel == SEL_LAST |=> !secondIndicator;
    endproperty
    a_second_off: assert property (p_second_off) else $error("second 111 not off");
endmodule // pleic_phy_led_int

// File: design/pleic_pkg.sv
/*
 * constants for the indicator and interrupt control block:
 * register indices, field positions, reset values, indicator codes.
 * assumes a 5-bit register index and 16-bit data from the management port.
 */
package pleic_pkg;
    // register indices
    localparam logic [4:0]  REG_INDICATOR  = 5'h14;
    localparam logic [4:0]  REG_RX_TALLY   = 5'h15;
    localparam logic [4:0]  REG_INT_CTRL   = 5'h16;
    localparam logic [4:0]  REG_INT_FLAGS  = 5'h17;
    // indicator_config fields and reset value
    localparam int          SECOND_SEL_LSB = 3;
    localparam int          FIRST_SEL_LSB  = 0;
    localparam logic [15:0] INDICATOR_RST  = 16'h3fe9;
    // indicator source codes
    localparam logic [2:0]  SEL_LINK       = 3'h0;
    localparam logic [2:0]  SEL_ACTIVITY   = 3'h1;
    localparam logic [2:0]  SEL_TX_DATA    = 3'h2;
    localparam logic [2:0]  SEL_RX_DATA    = 3'h3;
    localparam logic [2:0]  SEL_UNSUPP     = 3'h4;
    localparam logic [2:0]  SEL_SPEED      = 3'h5;
    localparam logic [2:0]  SEL_DUPLEX     = 3'h6;
    localparam logic [2:0]  SEL_LAST       = 3'h7;
    // interrupt_control field positions
    localparam int          OUT_EN_BIT     = 15;
    localparam int          READ_CLR_BIT   = 14;
    localparam int          POLARITY_BIT   = 13;
    localparam int          AUTO_CLR_BIT   = 12;
    localparam int          RESETUP_BIT    = 11;
    localparam int          EVENT_LSB      = 8;
    localparam int          NUM_EVENTS     = 3;
    localparam logic [15:0] INT_CTRL_RST   = 16'h0000;
    localparam logic [15:0] RX_TALLY_RST   = 16'h0000;
endpackage : pleic_pkg

// File: verif/pleic_sta_model.sv
/*
 * station management model: drives the register port of the block
 * with one-cycle strobes and takes read data one cycle later.
 * assumes the block samples its inputs on the rising clock edge.
 */
`timescale 1ns/1ps
module pleic_sta_model (
    // clock
    input  wire logic        clock,
    // read data from the block
    input  wire logic [15:0] regRdata,
    // register port
    output logic             regWrite,
    output logic             regRead,
    output logic      [4:0]  regIndex,
    output logic      [15:0] regWdata
);
    // idle port from time zero
    initial begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regIndex = 5'h00;
        regWdata = 16'h0000;
    end
    // write strobe; data inverted after use so no stale word looks valid
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        @(negedge clock);
        regIndex = idx;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        regWdata = ~d;
    endtask
    // read strobe; answer stands one cycle after the index
    task automatic rd(input logic [4:0] idx, output logic [15:0] d);
        @(negedge clock);
        regIndex = idx;
        regRead  = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        d       = regRdata;
    endtask
endmodule // pleic_sta_model

// File: verif/phy_led_and_interrupt_control_test.sv
/*
 * self-checking bench for the indicator, tally and interrupt block.
 * assumes the management model above; inputs change on falling edges.
 */
`timescale 1ns/1ps
module phy_led_and_interrupt_control_test;
    import pleic_pkg::*;
    logic        clock, srst, regWrite, regRead, rxErrorPulse, intPin, intPinOe;
    logic        linkUp, activity, txActive, rxActive, speed100, fullDuplex;
    logic        firstIndicator, secondIndicator;
    logic [4:0]  regIndex;
    logic [15:0] regWdata, regRdata, d;
    logic [2:0]  eventCond;
    int          err_count, samples_checked;
    pleic_phy_led_int u_pleic_phy_led_int (.clock(clock), .srst(srst), .regWrite(regWrite),
        .regRead(regRead), .regIndex(regIndex), .regWdata(regWdata), .regRdata(regRdata),
        .linkUp(linkUp), .activity(activity), .txActive(txActive), .rxActive(rxActive),
        .speed100(speed100), .fullDuplex(fullDuplex), .rxErrorPulse(rxErrorPulse),
        .eventCond(eventCond), .firstIndicator(firstIndicator),
        .secondIndicator(secondIndicator), .intPin(intPin), .intPinOe(intPinOe));
    pleic_sta_model u_sta (.clock(clock), .regRdata(regRdata), .regWrite(regWrite),
        .regRead(regRead), .regIndex(regIndex), .regWdata(regWdata));
    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // pin lags the condition by two edges; three gives margin
    task automatic pin(input logic e);
        repeat (3) @(negedge clock);
        chk({15'h0000, intPin}, {15'h0000, e});
    endtask
    // modes before enables, flags cleared in between
    task automatic arm(input logic [15:0] ctrl);
        eventCond = 3'h0;
        u_sta.wr(REG_INT_CTRL, ctrl & 16'hf800);
        u_sta.wr(REG_INT_FLAGS, 16'h0700);
        u_sta.wr(REG_INT_CTRL, ctrl);
    endtask
    task automatic t_reset;
        u_sta.rd(REG_INDICATOR, d);
        chk(d, INDICATOR_RST);
        u_sta.rd(REG_RX_TALLY, d);
        chk(d, 16'h0000);
        u_sta.rd(REG_INT_CTRL, d);
        chk(d, 16'h0000);
        chk({15'h0000, intPinOe}, 16'h0000);
    endtask
    // status pattern and its inverse, first and second fields crossed
    task automatic t_indicators;
        logic [7:0] ef, es;
        for (int p = 0; p < 2; p++) begin
            {linkUp, activity, txActive, rxActive} = p ? 4'h5 : 4'ha;
            {speed100, fullDuplex} = p ? 2'h1 : 2'h2;
            ef = p ? 8'h4a : 8'ha5;
            es = p ? 8'h4a : 8'h25;
            for (int c = 0; c < 8; c++) begin
                u_sta.wr(REG_INDICATOR, {10'h000, 3'(7 - c), 3'(c)});
                repeat (2) @(negedge clock);
                chk({15'h0000, firstIndicator}, {15'h0000, ef[c]});
                chk({15'h0000, secondIndicator}, {15'h0000, es[7 - c]});
            end
        end
    endtask
    task automatic t_tally;
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            rxErrorPulse = (i != 3);
            if (i == 3) begin
                u_sta.rd(REG_RX_TALLY, d);
                chk(d, 16'h0003);
                u_sta.wr(REG_RX_TALLY, 16'hffff);
            end
        end
        @(negedge clock);
        rxErrorPulse = 1'b1;
        @(negedge clock);
        rxErrorPulse = 1'b0;
        u_sta.rd(REG_RX_TALLY, d);
        chk(d, 16'h0000);
    endtask
    task automatic t_events;
        arm(16'h0700);
        eventCond = 3'h7;
        pin(1'b1);
        chk({15'h0000, intPinOe}, 16'h0000);
        arm(16'h8000);
        eventCond = 3'h7;
        pin(1'b1);
        chk({15'h0000, intPinOe}, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            arm(16'h8000 | (16'h0100 << i));
            eventCond[i] = 1'b1;
            pin(1'b0);
            eventCond = 3'h0;
            pin(1'b0);
            u_sta.rd(REG_INT_FLAGS, d);
            chk(d, 16'h0100 << i);
            pin(1'b0);
            u_sta.wr(REG_INT_FLAGS, 16'h0100 << i);
            pin(1'b1);
        end
    endtask
    task automatic t_modes;
        arm(16'he100);
        eventCond = 3'h1;
        pin(1'b1);
        u_sta.rd(REG_INT_FLAGS, d);
        chk(d, 16'h0100);
        pin(1'b0);
        arm(16'h9100);
        eventCond = 3'h1;
        pin(1'b0);
        eventCond = 3'h0;
        pin(1'b1);
        arm(16'h8900);
        u_sta.rd(REG_INT_CTRL, d);
        chk(d, 16'h8900);
        eventCond = 3'h1;
        u_sta.wr(REG_INT_FLAGS, 16'h0100);
        pin(1'b0);
        eventCond = 3'h0;
        u_sta.wr(REG_INT_FLAGS, 16'h0100);
        pin(1'b1);
    endtask
    // main sequence after a six-cycle reset
    initial begin
        {srst, rxErrorPulse, linkUp, activity, txActive, rxActive} = 6'h20;
        {speed100, fullDuplex, eventCond} = 5'h00;
        err_count = 0;
        samples_checked = 0;
        repeat (6) @(negedge clock);
        srst = 1'b0;
        t_reset();
        t_indicators();
        t_tally();
        t_events();
        t_modes();
        report_and_stop();
    end
    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule // phy_led_and_interrupt_control_test
